// >>> rtl/wdtu_pkg.sv
// Purpose: Shared constants and types for the watchdog timer unit
// Assumes: 50 MHz ref_clk, slow oscillator tick supplied as a one-cycle strobe
// Notes: Register offsets are local choices on the plain register port
package wdtu_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] OFF_CONTROL = 4'h0;
   localparam logic [3:0] OFF_CAUSE = 4'h1;
   localparam logic [3:0] OFF_IRQ_STATUS = 4'h2;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h3;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [7:0] CONTROL_RESET = 8'h53;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [4:0] KEY_ENABLE = 5'h0a;
   localparam int unsigned KEY_POS = 3;
   localparam int unsigned PERIOD_POS = 0;
   localparam int unsigned CAUSE_KEY_BIT = 0;
   localparam int unsigned CNT_W = 19;
   // Software reset delay in microseconds, and its cycle count
   localparam int unsigned SRESET_DELAY_US = 64;
   localparam int unsigned SRESET_CYCLES = SRESET_DELAY_US * (CLK_HZ / 1_000_000);
   // Status layout: bit0 timeout, bit1 power-down
   localparam int unsigned ST_TIMEOUT = 0;
   localparam int unsigned ST_PDOWN = 1;
   // Interrupt events: bit0 overflow, bit1 key fault
   localparam int unsigned EV_OVERFLOW = 0;
   localparam int unsigned EV_KEYFAULT = 1;
   localparam int unsigned EV_W = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdtu_req_t;

   typedef struct packed {
      logic wake_reset;   // Pulse: reset only program counter and stack pointer
      logic full_reset;   // Pulse: full device reset
   } wdtu_rst_t;
endpackage

// >>> rtl/wdtu_divider.sv
// Purpose: Watchdog count of slow oscillator ticks with selectable overflow
// Assumes: osc_tick is a one-cycle strobe per slow oscillator period
// Notes: Overflow is a one-cycle pulse, count restarts from zero after it
`timescale 1ns/100ps
module wdtu_divider #(
   parameter int unsigned CNT_W = wdtu_pkg::CNT_W
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic clear,
   input wire logic osc_tick,
   input wire logic [2:0] period_sel,
   output logic [CNT_W-1:0] count,
   output logic overflow
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic ovf;
   } wdtu_div_state_t;

   wdtu_div_state_t state_r;
   wdtu_div_state_t state_nxt;
   logic [4:0] shift;
   logic [CNT_W-1:0] limit;

   always_comb begin
      unique case (period_sel)
         3'd0: shift = 5'd8;
         3'd1: shift = 5'd10;
         3'd2: shift = 5'd12;
         3'd3: shift = 5'd14;
         3'd4: shift = 5'd15;
         3'd5: shift = 5'd16;
         3'd6: shift = 5'd17;
         3'd7: shift = 5'd18;
      endcase
      limit = CNT_W'((1 << shift) - 1);
   end

   always_comb begin
      state_nxt = state_r;
      state_nxt.ovf = 1'b0;
      if (clear || !run) begin
         state_nxt.cnt = '0;
      end else if (osc_tick) begin
         if (state_r.cnt >= limit) begin
            state_nxt.cnt = '0;
            state_nxt.ovf = 1'b1;
         end else begin
            state_nxt.cnt = state_r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign count = state_r.cnt;
   assign overflow = state_r.ovf;
endmodule

// >>> rtl/wdtu_top.sv
// Purpose: Watchdog timer unit with key field, period select and cause flags
// Assumes: Instruction strobes come from the core as one-cycle pulses
// Notes: resetn is power-up reset; wake and full reset requests are outputs
//
// Contract
// - Watchdog counts slow oscillator ticks, divided by two^8 up to two^18.
// - Period codes 000..111 pick 2^8,10,12,14,15,16,17,18 ticks.
// - Key 10101B disables the watchdog, 01010B enables it.
// - Any other key value forces a device reset after the software reset delay.
// - Key fault reset sets cause flag; only power-up or software writing zero clears it.
// - Control register powers up 0x53: enabled, period code 011.
// - Overflow while running requests full reset and sets timeout bit.
// - Overflow in sleep or idle sets timeout, resets only PC and stack.
// - Count cleared by key fault, clear instruction, power-down, reset pin low.
// - One clear instruction alone clears the counter.
// - Cause flag register bits 7 to 4 read as zero.
// - Power-down clears watchdog, sets power-down flag, clears timeout flag.
// - Power-down flag cleared by power-up or clear instruction.
`timescale 1ns/100ps
module wdtu_top #(
   parameter int unsigned SRESET_CYCLES = wdtu_pkg::SRESET_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire wdtu_pkg::wdtu_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic osc_tick,
   input wire logic clear_instr,
   input wire logic power_down_instr,
   input wire logic low_power_mode,
   input wire logic reset_pin_select,
   input wire logic reset_pin_n,
   output wdtu_pkg::wdtu_rst_t rst_req,
   output logic irq
);
   localparam int unsigned DLY_W = $clog2(SRESET_CYCLES + 1);

   typedef struct packed {
      logic [7:0] control;
      logic key_fault_reset_flag;
      logic timeout_status_bit;
      logic power_down_flag;
      logic [wdtu_pkg::EV_W-1:0] irq_status;
      logic [wdtu_pkg::EV_W-1:0] irq_mask;
      logic fault_pending;
      logic [DLY_W-1:0] delay;
      logic [7:0] rdata;
      wdtu_pkg::wdtu_rst_t rst;
      logic irq;
   } wdtu_state_t;

   wdtu_state_t state_r;
   wdtu_state_t state_nxt;
   logic [4:0] key;
   logic key_valid;
   logic run;
   logic wd_clear;
   logic overflow;
   logic [wdtu_pkg::EV_W-1:0] events;
   logic wr_ctl;

   assign key = state_r.control[wdtu_pkg::KEY_POS +: 5];
   assign key_valid = (key == wdtu_pkg::KEY_ENABLE) || (key == wdtu_pkg::KEY_DISABLE);
   assign run = (key == wdtu_pkg::KEY_ENABLE);
   assign wr_ctl = bus_req.wr && (bus_req.addr == wdtu_pkg::OFF_CONTROL);
   // Clear on any fault, including one from noise, not just a written one
   assign wd_clear = !key_valid || clear_instr || power_down_instr
      || (reset_pin_select && !reset_pin_n);

   wdtu_divider #(
      .CNT_W(wdtu_pkg::CNT_W)
   ) u_div (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .run(run),
      .clear(wd_clear),
      .osc_tick(osc_tick),
      .period_sel(state_r.control[wdtu_pkg::PERIOD_POS +: 3]),
      .count(),
      .overflow(overflow)
   );

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      state_nxt = state_r;
      state_nxt.rst = '0;
      state_nxt.rdata = 8'h00;
      events = '0;

      // Software writes
      if (wr_ctl) begin
         state_nxt.control = bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == wdtu_pkg::OFF_CAUSE && !bus_req.wdata[0]) begin
         state_nxt.key_fault_reset_flag = 1'b0;
      end
      if (bus_req.wr && bus_req.addr == wdtu_pkg::OFF_IRQ_STATUS) begin
         state_nxt.irq_status = state_r.irq_status & ~bus_req.wdata[wdtu_pkg::EV_W-1:0];
      end
      if (bus_req.wr && bus_req.addr == wdtu_pkg::OFF_IRQ_MASK) begin
         state_nxt.irq_mask = bus_req.wdata[wdtu_pkg::EV_W-1:0];
      end

      // Key fault: hold off, then full reset
      if (!key_valid && !state_r.fault_pending) begin
         state_nxt.fault_pending = 1'b1;
         state_nxt.delay = '0;
         events[wdtu_pkg::EV_KEYFAULT] = 1'b1;
      end else if (state_r.fault_pending) begin
         if (state_r.delay >= DLY_W'(SRESET_CYCLES - 1)) begin
            state_nxt.rst.full_reset = 1'b1;
            state_nxt.key_fault_reset_flag = 1'b1;
            state_nxt.fault_pending = 1'b0;
            state_nxt.delay = '0;
            // Reset returns the key to its power-up value
            state_nxt.control = wdtu_pkg::CONTROL_RESET;
         end else begin
            state_nxt.delay = state_r.delay + 1'b1;
         end
      end

      // Clear instruction and power-down
      if (clear_instr) begin
         state_nxt.power_down_flag = 1'b0;
      end
      if (power_down_instr) begin
         state_nxt.power_down_flag = 1'b1;
         state_nxt.timeout_status_bit = 1'b0;
      end

      // Overflow: set wins over any simultaneous clear
      if (overflow) begin
         state_nxt.timeout_status_bit = 1'b1;
         events[wdtu_pkg::EV_OVERFLOW] = 1'b1;
         if (low_power_mode) begin
            state_nxt.rst.wake_reset = 1'b1;
         end else begin
            state_nxt.rst.full_reset = 1'b1;
         end
      end

      state_nxt.irq_status = state_nxt.irq_status | events;
      state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);

      if (bus_req.rd) begin
         unique case (bus_req.addr)
            wdtu_pkg::OFF_CONTROL: state_nxt.rdata = state_r.control;
            wdtu_pkg::OFF_CAUSE: state_nxt.rdata = {7'h00, state_r.key_fault_reset_flag};
            wdtu_pkg::OFF_IRQ_STATUS: state_nxt.rdata = {6'h00, state_r.irq_status};
            wdtu_pkg::OFF_IRQ_MASK: state_nxt.rdata = {6'h00, state_r.irq_mask};
            wdtu_pkg::OFF_STATUS: state_nxt.rdata = {6'h00, state_r.power_down_flag,
               state_r.timeout_status_bit};
            default: state_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_r <= '0;
         state_r.control <= wdtu_pkg::CONTROL_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign rdata = state_r.rdata;
   assign rst_req = state_r.rst;
   assign irq = state_r.irq;
endmodule

// >>> tb/wdtu_properties.sv
// Purpose: Port-level properties of the watchdog timer unit
// Assumes: One ref_clk domain, resetn synchronous active low
// Notes: Bound to wdtu_top below
`timescale 1ns/100ps
module wdtu_properties #(
   parameter int unsigned SRESET_CYCLES = wdtu_pkg::SRESET_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire wdtu_pkg::wdtu_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic osc_tick,
   input wire logic clear_instr,
   input wire logic low_power_mode,
   input wire wdtu_pkg::wdtu_rst_t rst_req,
   input wire logic irq
);
   localparam int LO = SRESET_CYCLES - 1;
   localparam int HI = SRESET_CYCLES + 4;
   logic key_bad_wr;
   assign key_bad_wr = bus_req.wr && bus_req.addr == wdtu_pkg::OFF_CONTROL
      && bus_req.wdata[7:3] != wdtu_pkg::KEY_ENABLE && bus_req.wdata[7:3] != wdtu_pkg::KEY_DISABLE;
   // Cycles since the last bad key write, saturating past the fault window
   int since_bad;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         since_bad <= HI + 1;
      end else if (key_bad_wr) begin
         since_bad <= 0;
      end else if (since_bad <= HI) begin
         since_bad <= since_bad + 1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////
   property p_rdata_idle;
      !$past(bus_req.rd) |-> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata without read");
   property p_cause_upper;
      $past(bus_req.rd) && $past(bus_req.addr) == wdtu_pkg::OFF_CAUSE |-> rdata[7:4] == 4'h0;
   endproperty
   a_cause_upper: assert property (p_cause_upper) else $error("cause upper bits set");
   property p_one_kind;
      !(rst_req.full_reset && rst_req.wake_reset);
   endproperty
   a_one_kind: assert property (p_one_kind) else $error("both reset kinds");
   property p_full_pulse;
      rst_req.full_reset |=> !rst_req.full_reset;
   endproperty
   a_full_pulse: assert property (p_full_pulse) else $error("full reset too long");
   property p_wake_mode;
      rst_req.wake_reset |-> $past(low_power_mode);
   endproperty
   a_wake_mode: assert property (p_wake_mode) else $error("wake reset while running");
   property p_key_early;
      key_bad_wr |=> (!rst_req.full_reset)[*6];
   endproperty
   a_key_early: assert property (p_key_early) else $error("key fault reset early");
   property p_key_late;
      key_bad_wr |-> ##[LO:HI] rst_req.full_reset;
   endproperty
   a_key_late: assert property (p_key_late) else $error("key fault reset missing");
   property p_clear_quiet;
      clear_instr && !osc_tick && !$past(osc_tick) && since_bad > HI
         |=> (!rst_req.full_reset && !rst_req.wake_reset)[*3];
   endproperty
   a_clear_quiet: assert property (p_clear_quiet) else $error("overflow after clear");
   property p_mask_off;
      bus_req.wr && bus_req.addr == wdtu_pkg::OFF_IRQ_MASK && bus_req.wdata == 8'h00
         |-> ##2 (!irq)[*3];
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq while masked");
endmodule
bind wdtu_top wdtu_properties #(.SRESET_CYCLES(SRESET_CYCLES)) u_props (.ref_clk(ref_clk),
   .resetn(resetn), .bus_req(bus_req), .rdata(rdata), .osc_tick(osc_tick),
   .clear_instr(clear_instr), .low_power_mode(low_power_mode), .rst_req(rst_req), .irq(irq));

// >>> tb/wdtu_test.sv
// Purpose: Self-checking bench for the watchdog timer unit
// Assumes: Software reset delay shortened to 8 cycles
// Notes: osc_tick strobes every second cycle to keep long periods short
`timescale 1ns/100ps
module wdtu_test;
   logic ref_clk = 0, resetn = 0, osc_tick = 0, clear_instr = 0, power_down_instr = 0;
   logic low_power_mode = 0, reset_pin_select = 0, reset_pin_n = 1, irq;
   wdtu_pkg::wdtu_req_t bus_req = '0;
   wdtu_pkg::wdtu_rst_t rst_req;
   logic [7:0] rdata;
   int n_fail = 0, tests_run = 0, n_full = 0, n_wake = 0;
   int pw[4] = '{8, 10, 12, 14};
   wdtu_top #(.SRESET_CYCLES(8)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
      .rdata(rdata), .osc_tick(osc_tick), .clear_instr(clear_instr),
      .power_down_instr(power_down_instr), .low_power_mode(low_power_mode),
      .reset_pin_select(reset_pin_select), .reset_pin_n(reset_pin_n), .rst_req(rst_req),
      .irq(irq));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      n_full <= n_full + int'(rst_req.full_reset === 1'b1);
      n_wake <= n_wake + int'(rst_req.wake_reset === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk) bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk) bus_req.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge ref_clk) osc_tick <= 1'b1;
         @(posedge ref_clk) osc_tick <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic clr;
      @(posedge ref_clk) clear_instr <= 1'b1;
      @(posedge ref_clk) clear_instr <= 1'b0;
   endtask
   task automatic see_irq(input logic e);
      repeat (3) @(posedge ref_clk);
      #1 chk(irq, e);
   endtask
   task automatic pin_pulse;
      @(posedge ref_clk) reset_pin_n <= 1'b0;
      @(posedge ref_clk) reset_pin_n <= 1'b1;
   endtask
   task automatic wrap_up;
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Expected run is about 50000 cycles
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(wdtu_pkg::OFF_CONTROL, 8'h53);
      rd(wdtu_pkg::OFF_CAUSE, 8'h00);
      rd(4'hf, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(wdtu_pkg::OFF_CONTROL, {wdtu_pkg::KEY_ENABLE, i[2:0]});
         clr();
         ticks((1 << pw[i]) - 1);
         chk(n_full, i);
         ticks(1);
         chk(n_full, i + 1);
      end
      rd(wdtu_pkg::OFF_STATUS, 8'h01);
      wr(wdtu_pkg::OFF_IRQ_MASK, 8'h01);
      see_irq(1'b1);
      wr(wdtu_pkg::OFF_IRQ_MASK, 8'h00);
      see_irq(1'b0);
      wr(wdtu_pkg::OFF_IRQ_MASK, 8'h01);
      wr(wdtu_pkg::OFF_IRQ_STATUS, 8'h01);
      rd(wdtu_pkg::OFF_IRQ_MASK, 8'h01);
      see_irq(1'b0);
      wr(wdtu_pkg::OFF_CONTROL, 8'h50);
      clr();
      ticks(200);
      clr();
      ticks(200);
      chk(n_full, 4);
      reset_pin_select <= 1'b1;
      pin_pulse();
      ticks(200);
      chk(n_full, 4);
      reset_pin_select <= 1'b0;
      pin_pulse();
      ticks(56);
      chk(n_full, 5);
      ticks(200);
      @(posedge ref_clk) power_down_instr <= 1'b1;
      @(posedge ref_clk) power_down_instr <= 1'b0;
      rd(wdtu_pkg::OFF_STATUS, 8'h02);
      ticks(200);
      chk(n_full, 5);
      clr();
      rd(wdtu_pkg::OFF_STATUS, 8'h00);
      low_power_mode <= 1'b1;
      ticks(256);
      chk(n_wake, 1);
      chk(n_full, 5);
      rd(wdtu_pkg::OFF_STATUS, 8'h01);
      low_power_mode <= 1'b0;
      wr(wdtu_pkg::OFF_CONTROL, 8'ha8);
      rd(wdtu_pkg::OFF_CONTROL, 8'ha8);
      ticks(300);
      chk(n_full, 5);
      wr(wdtu_pkg::OFF_CONTROL, 8'hf8);
      repeat (14) @(posedge ref_clk);
      chk(n_full, 6);
      rd(wdtu_pkg::OFF_IRQ_STATUS, 8'h03);
      rd(wdtu_pkg::OFF_CAUSE, 8'h01);
      rd(wdtu_pkg::OFF_CONTROL, 8'h53);
      wr(wdtu_pkg::OFF_CAUSE, 8'h01);
      rd(wdtu_pkg::OFF_CAUSE, 8'h01);
      wr(wdtu_pkg::OFF_CAUSE, 8'h00);
      rd(wdtu_pkg::OFF_CAUSE, 8'h00);
      wrap_up();
   end
endmodule
